// ### rtl/teletext_header_roll_and_error_check.sv
// Purpose: Teletext acquisition write control: rolling headers, time, page clear, checks
// Assumes: Decoded bytes arrive with packet, magazine and position; page match is external
// Notes:   One memory write per cycle; received bytes always win the write port
// Operation
// - Writing request data sets that block's changed flag at bit 5, column 9, row 25.
// - Per-block flag state is refreshed once per field on TV line 1.
// - Flagged display block takes valid headers and a green code at row 0 column 7.
// - First acquisition clears rows 1 to 23 of the block to space 20H.
// - That clear also covers row 24 when row-24 placement is set.
// - That clear also covers the page's extension rows when extension packets are off, for blocks below 9.
// - Last eight header characters go into the display block as time.
// - Header-roll disable blocks row 0 writes except an acquired page header.
// - Acquisition-off stops every write into page memory.
// - Parallel mode: only headers of the requested magazine count as valid.
// - Serial mode: every header counts as valid.
// - Every byte is checked per packet, position, check mode and eight-bit mode.
// - Hamming failure in header control or 8/30 bytes stores byte with bit 4 set.
// - Hamming failure in other protected bytes leaves memory unchanged.
// - Request's two check mode bits select checks for packets 1 to 23.
// - Reset requests match any page, hold on, check mode 0.
// - First eight header bytes are decoded into columns 0 to 7 of row 25.
`timescale 1ns/1ps
module teletext_header_roll_and_error_check
  import teletext_acq_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [15:0] reg_rdata_o,
  // Line timing
  input wire logic tv_line_i,
  input wire logic field_line1_i,
  // Decoded packet bytes
  input wire logic byte_valid_i,
  input wire logic [4:0] pkt_num_i,
  input wire logic [2:0] pkt_mag_i,
  input wire logic [5:0] byte_pos_i,
  input wire logic [7:0] byte_i,
  input wire logic hdr_match_i,
  input wire logic [3:0] match_block_i,
  // Page memory write port
  output logic mem_we_o,
  output logic [3:0] mem_block_o,
  output logic [4:0] mem_row_o,
  output logic [5:0] mem_col_o,
  output logic [7:0] mem_data_o,
  // Status
  output logic clearing_o,
  output logic irq_o
);
  typedef enum {CLR_IDLE, CLR_TEXT, CLR_EXT} clr_state_t;

  logic [4:0] req_ram_q [NUM_REQ*REQ_COLS];
  logic [4:0] req_ram_d [NUM_REQ*REQ_COLS];
  logic [15:0] ctrl_q, ctrl_d, rdata_q, rdata_d;
  logic [3:0] sel_req_q, sel_req_d;
  logic [2:0] sel_col_q, sel_col_d;
  logic [NUM_REQ-1:0] flag_q, flag_d, live_q, live_d, request_changed_flag_q, request_changed_flag_d;
  logic [IRQ_W-1:0] status_q, status_d, mask_q, mask_d, ev;
  logic irq_q, irq_d, green_q, green_d;
  logic roll_q, roll_d;
  logic [5:0] roll_col_q, roll_col_d;
  logic [7:0] roll_data_q, roll_data_d;
  logic acq_on_q, acq_on_d;
  logic [3:0] acq_blk_q, acq_blk_d;
  logic [2:0] acq_mag_q, acq_mag_d;
  clr_state_t clr_q, clr_d;
  logic [3:0] clr_blk_q, clr_blk_d;
  logic [4:0] clr_row_q, clr_row_d, clr_last_q, clr_last_d;
  logic [5:0] clr_col_q, clr_col_d;
  logic we_q, we_d;
  logic [3:0] blk_q, blk_d;
  logic [4:0] row_q, row_d;
  logic [5:0] col_q, col_d;
  logic [7:0] data_q, data_d;

  logic [3:0] disp;
  logic [1:0] mode;
  check_t kind;
  logic [3:0] ham_nib;
  logic ham_ok, par_ok, lenient, keep, hdr_valid, hit, page_pkt, dir_w, roll_w;
  logic [6:0] par_data;
  logic [7:0] chk_data;
  logic [3:0] dir_blk;
  logic [4:0] dir_row;

  hamming84_decode u_ham (
    .code_i(byte_i),
    .nibble_o(ham_nib),
    .ok_o(ham_ok)
  );

  odd_parity_check u_par (
    .code_i(byte_i),
    .data_o(par_data),
    .ok_o(par_ok)
  );

  // Byte checking and write target of the arriving byte
  always_comb begin
    disp = ctrl_q[CTRL_DISP_LSB +: 4];
    page_pkt = pkt_num_i != PKT_HDR && pkt_num_i <= PKT_LAST_TEXT;
    mode = page_pkt ? req_ram_q[{acq_blk_q, REQ_COL_MODE}][1:0] : 2'h0;
    kind = check_kind(pkt_num_i, byte_pos_i, mode, ctrl_q[CTRL_EIGHT]);
    lenient = (pkt_num_i == PKT_HDR && byte_pos_i <= HDR_CTRL_LAST) ||
              (pkt_num_i == PKT_X30 && pkt_mag_i == MAG_EIGHT);
    chk_data = byte_i;
    keep = 1'b1;
    if (kind == CHK_PARITY) begin
      chk_data = {1'b0, par_data};
      keep = par_ok;
    end else if (kind == CHK_HAMMING) begin
      chk_data = {3'h0, 1'b0, ham_nib};
      chk_data[HAM_ERR_BIT] = ~ham_ok;
      keep = ham_ok | lenient;
    end
    // Parallel mode trusts only the display request's magazine
    hdr_valid = !ctrl_q[CTRL_PARALLEL] ||
                pkt_mag_i == req_ram_q[{disp, REQ_COL_MAG}][2:0];
    hit = pkt_num_i == PKT_HDR && hdr_match_i;
    dir_w = 1'b0;
    dir_blk = acq_blk_q;
    dir_row = pkt_num_i;
    if (hit) begin
      dir_w = 1'b1;
      dir_blk = match_block_i;
      dir_row = (byte_pos_i <= HDR_CTRL_LAST) ? ROW_CTRL : ROW_HDR;
    end else if (acq_on_q && pkt_mag_i == acq_mag_q) begin
      if (page_pkt) begin
        dir_w = 1'b1;
      end else if (pkt_num_i == PKT_X24) begin
        dir_w = ctrl_q[CTRL_X24] || !ctrl_q[CTRL_EXT_OFF];
        dir_blk = ctrl_q[CTRL_X24] ? acq_blk_q : EXT_BLOCK;
        dir_row = ctrl_q[CTRL_X24] ? ROW_X24 : ext_row(acq_blk_q);
      end else if (pkt_num_i == PKT_X27) begin
        dir_w = !ctrl_q[CTRL_EXT_OFF];
        dir_blk = EXT_BLOCK;
        dir_row = ext_row(acq_blk_q) + 5'h01;
      end
    end
    if (pkt_num_i == PKT_X30 && pkt_mag_i == MAG_EIGHT && !ctrl_q[CTRL_EXT_OFF]) begin
      dir_w = 1'b1;
      dir_blk = EXT_BLOCK;
      dir_row = ROW_P830;
    end
    // Rolling header while flagged, time always, both gated by roll disable
    roll_w = pkt_num_i == PKT_HDR && hdr_valid && !ctrl_q[CTRL_ROLL_DIS] &&
             byte_pos_i > HDR_CTRL_LAST &&
             (live_q[disp] || byte_pos_i >= COL_TIME_FIRST) &&
             !(hit && match_block_i == disp);
    dir_w = dir_w && byte_valid_i && keep;
    roll_w = roll_w && byte_valid_i && keep;
  end

  // Register port, flags, pending writes, clear engine and write arbitration
  always_comb begin
    req_ram_d = req_ram_q;
    ctrl_d = ctrl_q;
    sel_req_d = sel_req_q;
    sel_col_d = sel_col_q;
    flag_d = flag_q;
    live_d = live_q;
    request_changed_flag_d = request_changed_flag_q;
    mask_d = mask_q;
    ev = '0;
    rdata_d = 16'h0000;
    green_d = green_q;
    roll_d = roll_q;
    roll_col_d = roll_col_q;
    roll_data_d = roll_data_q;
    acq_on_d = acq_on_q;
    acq_blk_d = acq_blk_q;
    acq_mag_d = acq_mag_q;
    clr_d = clr_q;
    clr_blk_d = clr_blk_q;
    clr_row_d = clr_row_q;
    clr_col_d = clr_col_q;
    clr_last_d = clr_last_q;
    we_d = 1'b0;
    blk_d = blk_q;
    row_d = row_q;
    col_d = col_q;
    data_d = data_q;
    // Software writes
    if (reg_we_i) begin
      case (reg_addr_i)
        REG_CTRL: ctrl_d = reg_wdata_i;
        REG_REQ_SEL: {sel_req_d, sel_col_d} = reg_wdata_i[SEL_COL_W +: 7];
        REG_REQ_DATA: begin
          // Requests beyond the last block are ignored
          if (sel_req_q < 4'(NUM_REQ)) begin
            req_ram_d[{sel_req_q, sel_col_q}] = reg_wdata_i[4:0];
            sel_col_d = sel_col_q + 3'h1;
            flag_d[sel_req_q] = 1'b1;
            request_changed_flag_d[sel_req_q] = 1'b1;
          end
        end
        REG_MASK: mask_d = reg_wdata_i[IRQ_W-1:0];
        default: ;
      endcase
    end
    // Software reads, answered in the following cycle only
    if (reg_re_i) begin
      case (reg_addr_i)
        REG_CTRL: rdata_d = ctrl_q;
        REG_REQ_SEL: rdata_d = 16'({sel_req_q, sel_col_q});
        REG_REQ_DATA: rdata_d = 16'(req_ram_q[{sel_req_q, sel_col_q}]);
        REG_FLAGS: rdata_d = 16'(live_q);
        REG_STATUS: rdata_d = 16'(status_q);
        REG_MASK: rdata_d = 16'(mask_q);
        default: rdata_d = 16'h0000;
      endcase
    end
    if (field_line1_i) live_d = flag_d;
    if (tv_line_i && live_q[disp] && !ctrl_q[CTRL_ROLL_DIS]) green_d = 1'b1;
    // Header position 0 decides whether the following packets belong to a page
    if (byte_valid_i && pkt_num_i == PKT_HDR && byte_pos_i == 6'h00) begin
      if (hdr_match_i) begin
        acq_on_d = 1'b1;
        acq_blk_d = match_block_i;
        acq_mag_d = pkt_mag_i;
        // Only one page clear at a time; a clear already running keeps going
        if (flag_q[match_block_i] && clr_q == CLR_IDLE) begin
          flag_d[match_block_i] = 1'b0;
          clr_d = CLR_TEXT;
          clr_blk_d = match_block_i;
          clr_row_d = ROW_FIRST_TEXT;
          clr_col_d = 6'h00;
          clr_last_d = ctrl_q[CTRL_X24] ? ROW_X24 : ROW_LAST_TEXT;
        end
      end else if (pkt_mag_i == acq_mag_q) begin
        acq_on_d = 1'b0;
      end
    end
    // Write port: received byte, then rolling, green, flag writes, clear
    if (dir_w) begin
      we_d = 1'b1;
      {blk_d, row_d, col_d, data_d} = {dir_blk, dir_row, byte_pos_i, chk_data};
      if (roll_w) begin
        roll_d = 1'b1;
        roll_col_d = byte_pos_i;
        roll_data_d = chk_data;
      end
    end else if (roll_w) begin
      we_d = 1'b1;
      {blk_d, row_d, col_d, data_d} = {disp, ROW_HDR, byte_pos_i, chk_data};
    end else if (roll_q) begin
      we_d = 1'b1;
      roll_d = 1'b0;
      {blk_d, row_d, col_d, data_d} = {disp, ROW_HDR, roll_col_q, roll_data_q};
    end else if (green_q) begin
      we_d = 1'b1;
      green_d = 1'b0;
      {blk_d, row_d, col_d, data_d} = {disp, ROW_HDR, COL_GREEN, GREEN_CODE};
    end else if (|request_changed_flag_q) begin
      we_d = 1'b1;
      for (int i = NUM_REQ - 1; i >= 0; i--) begin
        if (request_changed_flag_q[i]) blk_d = 4'(i);
      end
      request_changed_flag_d[blk_d] = 1'b0;
      {row_d, col_d, data_d} = {ROW_CTRL, COL_REQUEST_CHANGED_FLAG, REQUEST_CHANGED_FLAG_BYTE};
    end else if (clr_q != CLR_IDLE) begin
      we_d = 1'b1;
      blk_d = (clr_q == CLR_EXT) ? EXT_BLOCK : clr_blk_q;
      {row_d, col_d, data_d} = {clr_row_q, clr_col_q, SPACE_CODE};
      clr_col_d = clr_col_q + 6'h01;
      if (clr_col_q == COL_LAST) begin
        clr_col_d = 6'h00;
        clr_row_d = clr_row_q + 5'h01;
        if (clr_row_q == clr_last_q) begin
          if (clr_q == CLR_TEXT && ctrl_q[CTRL_EXT_OFF] && clr_blk_q < EXT_BLOCK) begin
            clr_d = CLR_EXT;
            clr_row_d = ext_row(clr_blk_q);
            clr_last_d = ext_row(clr_blk_q) + 5'h01;
          end else begin
            clr_d = CLR_IDLE;
            ev[IRQ_CLEAR_DONE] = 1'b1;
          end
        end
      end
    end
    if (ctrl_q[CTRL_ACQ_OFF]) we_d = 1'b0;
    ev[IRQ_HAM_ERR] = byte_valid_i && kind == CHK_HAMMING && !ham_ok;
    ev[IRQ_PAR_ERR] = byte_valid_i && kind == CHK_PARITY && !par_ok;
    // Write-one-to-clear, a new event in the same cycle wins
    status_d = status_q;
    if (reg_we_i && reg_addr_i == REG_STATUS) status_d = status_q & ~reg_wdata_i[IRQ_W-1:0];
    status_d = status_d | ev;
    irq_d = |(status_d & mask_d);
  end

  // State registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_REQ * REQ_COLS; i++) begin
        req_ram_q[i] <= (i % REQ_COLS == 0) ? REQ_RESET_COL0 : REQ_RESET_OTHER;
      end
      ctrl_q <= 16'h0000;
      sel_req_q <= 4'h0;
      sel_col_q <= 3'h0;
      flag_q <= '0;
      live_q <= '0;
      request_changed_flag_q <= '0;
      status_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
      rdata_q <= 16'h0000;
      green_q <= 1'b0;
      roll_q <= 1'b0;
      roll_col_q <= 6'h00;
      roll_data_q <= 8'h00;
      acq_on_q <= 1'b0;
      acq_blk_q <= 4'h0;
      acq_mag_q <= 3'h0;
      clr_q <= CLR_IDLE;
      clr_blk_q <= 4'h0;
      clr_row_q <= 5'h00;
      clr_col_q <= 6'h00;
      clr_last_q <= 5'h00;
      we_q <= 1'b0;
      blk_q <= 4'h0;
      row_q <= 5'h00;
      col_q <= 6'h00;
      data_q <= 8'h00;
    end else begin
      req_ram_q <= req_ram_d;
      ctrl_q <= ctrl_d;
      sel_req_q <= sel_req_d;
      sel_col_q <= sel_col_d;
      flag_q <= flag_d;
      live_q <= live_d;
      request_changed_flag_q <= request_changed_flag_d;
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
      green_q <= green_d;
      roll_q <= roll_d;
      roll_col_q <= roll_col_d;
      roll_data_q <= roll_data_d;
      acq_on_q <= acq_on_d;
      acq_blk_q <= acq_blk_d;
      acq_mag_q <= acq_mag_d;
      clr_q <= clr_d;
      clr_blk_q <= clr_blk_d;
      clr_row_q <= clr_row_d;
      clr_col_q <= clr_col_d;
      clr_last_q <= clr_last_d;
      we_q <= we_d;
      blk_q <= blk_d;
      row_q <= row_d;
      col_q <= col_d;
      data_q <= data_d;
    end
  end

  // Outputs straight from flip-flops; clearing_o decoded from the clear state
  assign reg_rdata_o = rdata_q;
  assign mem_we_o = we_q;
  assign mem_block_o = blk_q;
  assign mem_row_o = row_q;
  assign mem_col_o = col_q;
  assign mem_data_o = data_q;
  assign clearing_o = clr_q != CLR_IDLE;
  assign irq_o = irq_q;
endmodule

// ### rtl/teletext_acq_pkg.sv
// Purpose: Shared constants, types and functions of the Teletext write-control block
// Assumes: Page memory addressed as block / row / column, one byte per location
// Notes:   Check-kind table encodes which error check each received byte gets
package teletext_acq_pkg;
  localparam int NUM_REQ = 12;
  localparam int REQ_COLS = 8;
  // Register map (word index on the plain register port)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_REQ_SEL = 4'h1;
  localparam logic [3:0] REG_REQ_DATA = 4'h2;
  localparam logic [3:0] REG_FLAGS = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_MASK = 4'h5;
  // Control register fields
  localparam int CTRL_ROLL_DIS = 0;
  localparam int CTRL_X24 = 1;
  localparam int CTRL_EXT_OFF = 2;
  localparam int CTRL_ACQ_OFF = 3;
  localparam int CTRL_EIGHT = 4;
  localparam int CTRL_PARALLEL = 5;
  localparam int CTRL_DISP_LSB = 8;
  localparam int SEL_COL_W = 3;
  // Page request RAM layout and reset contents
  localparam logic [2:0] REQ_COL_MAG = 3'h0;
  localparam logic [2:0] REQ_COL_MODE = 3'h7;
  localparam logic [4:0] REQ_RESET_COL0 = 5'h08;
  localparam logic [4:0] REQ_RESET_OTHER = 5'h00;
  // Interrupt status bits
  localparam int IRQ_CLEAR_DONE = 0;
  localparam int IRQ_HAM_ERR = 1;
  localparam int IRQ_PAR_ERR = 2;
  localparam int IRQ_W = 3;
  // Page memory geometry and codes
  localparam logic [4:0] ROW_HDR = 5'h00;
  localparam logic [4:0] ROW_FIRST_TEXT = 5'h01;
  localparam logic [4:0] ROW_LAST_TEXT = 5'h17;
  localparam logic [4:0] ROW_X24 = 5'h18;
  localparam logic [4:0] ROW_CTRL = 5'h19;
  localparam logic [4:0] ROW_P830 = 5'h02;
  localparam logic [5:0] COL_LAST = 6'h27;
  localparam logic [5:0] COL_GREEN = 6'h07;
  localparam logic [5:0] COL_REQUEST_CHANGED_FLAG = 6'h09;
  localparam logic [5:0] COL_TIME_FIRST = 6'h20;
  localparam logic [5:0] HDR_CTRL_LAST = 6'h07;
  localparam logic [5:0] P830_HAM_LAST = 6'h0c;
  localparam logic [3:0] EXT_BLOCK = 4'h9;
  localparam logic [7:0] REQUEST_CHANGED_FLAG_BYTE = 8'h20;
  localparam logic [7:0] GREEN_CODE = 8'h02;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam int HAM_ERR_BIT = 4;
  // Packet numbers
  localparam logic [4:0] PKT_HDR = 5'h00;
  localparam logic [4:0] PKT_LAST_TEXT = 5'h17;
  localparam logic [4:0] PKT_X24 = 5'h18;
  localparam logic [4:0] PKT_X27 = 5'h1b;
  localparam logic [4:0] PKT_X30 = 5'h1e;
  localparam logic [2:0] MAG_EIGHT = 3'h0;

  typedef enum logic [1:0] {CHK_NONE, CHK_PARITY, CHK_HAMMING} check_t;

  // Extension row of a page block inside the extension block
  function automatic logic [4:0] ext_row(input logic [3:0] blk);
    ext_row = (blk == 4'h0) ? 5'h00 : 5'({blk, 1'b0} + 5'h02);
  endfunction

  // Error check applied to one byte
  function automatic check_t check_kind(input logic [4:0] pkt, input logic [5:0] pos,
                                        input logic [1:0] mode, input logic eight);
    check_kind = CHK_NONE;
    if (pkt == PKT_HDR) begin
      if (pos <= HDR_CTRL_LAST) check_kind = CHK_HAMMING;
      else if (!eight) check_kind = CHK_PARITY;
    end else if (pkt <= PKT_LAST_TEXT) begin
      if (!eight) begin
        case (mode)
          2'h0: check_kind = CHK_PARITY;
          2'h2: check_kind = CHK_HAMMING;
          default: check_kind = CHK_NONE;
        endcase
      end
    end else if (pkt == PKT_X24) begin
      if (!eight) check_kind = CHK_PARITY;
    end else if (pkt == PKT_X27) begin
      check_kind = CHK_HAMMING;
    end else if (pkt == PKT_X30) begin
      if (pos <= P830_HAM_LAST) check_kind = CHK_HAMMING;
      else if (!eight) check_kind = CHK_PARITY;
    end
  endfunction
endpackage

// ### rtl/hamming84_decode.sv
// Purpose: Hamming 8/4 decoder with single-error correction
// Assumes: Data bits at odd positions, protection bits at even positions
// Notes:   Double errors are flagged, never corrected
`timescale 1ns/1ps
module hamming84_decode (
  // Received byte
  input wire logic [7:0] code_i,
  // Decoded nibble and result
  output logic [3:0] nibble_o,
  output logic ok_o
);
  logic fail_a, fail_b, fail_c, par_good;
  logic [7:0] fixed;

  // Each group must show odd parity; overall parity tells single from double
  always_comb begin
    fail_a = ~(code_i[0] ^ code_i[1] ^ code_i[5] ^ code_i[7]);
    fail_b = ~(code_i[2] ^ code_i[1] ^ code_i[3] ^ code_i[7]);
    fail_c = ~(code_i[4] ^ code_i[1] ^ code_i[3] ^ code_i[5]);
    par_good = ^code_i;
    fixed = code_i;
    if (!par_good) begin
      case ({fail_c, fail_b, fail_a})
        3'h7: fixed[1] = ~code_i[1];
        3'h6: fixed[3] = ~code_i[3];
        3'h5: fixed[5] = ~code_i[5];
        3'h3: fixed[7] = ~code_i[7];
        default: fixed = code_i; // Protection bit hit, data intact
      endcase
    end
    nibble_o = {fixed[7], fixed[5], fixed[3], fixed[1]};
    ok_o = ~par_good | ~(fail_a | fail_b | fail_c);
  end
endmodule

// ### rtl/odd_parity_check.sv
// Purpose: Odd parity check of one 8-bit Teletext character
// Assumes: Bit 7 is the parity bit
// Notes:   Stored character has the parity bit removed
`timescale 1ns/1ps
module odd_parity_check (
  // Received byte
  input wire logic [7:0] code_i,
  // Character and result
  output logic [6:0] data_o,
  output logic ok_o
);
  // Parity bit stripped, result kept apart
  assign data_o = code_i[6:0];
  assign ok_o = ^code_i;
endmodule

// ### test/acq_checker_assertions.sv
// Purpose: Port-level checks of the write-control block
// Assumes: Control register shadowed from port writes
// Notes:   Checks write timing and values, not memory contents
`timescale 1ns/1ps
module acq_checker
  import teletext_acq_pkg::*;
(
  // Clock, reset and register port
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [15:0] reg_rdata_o,
  // Decoded bytes
  input wire logic byte_valid_i,
  input wire logic [4:0] pkt_num_i,
  input wire logic [5:0] byte_pos_i,
  input wire logic [7:0] byte_i,
  input wire logic hdr_match_i,
  input wire logic [3:0] match_block_i,
  // Memory port
  input wire logic mem_we_o,
  input wire logic [3:0] mem_block_o,
  input wire logic [4:0] mem_row_o,
  input wire logic [5:0] mem_col_o,
  input wire logic [7:0] mem_data_o,
  input wire logic clearing_o
);
  logic [15:0] ctrl_d, ctrl_q;
  logic roll, off;
  // Control register shadow for the inhibits
  always_comb begin
    ctrl_d = ctrl_q;
    if (reg_we_i && reg_addr_i == REG_CTRL) ctrl_d = reg_wdata_i;
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) ctrl_q <= 16'h0000;
    else ctrl_q <= ctrl_d;
  end
  assign roll = ctrl_q[CTRL_ROLL_DIS];
  assign off = ctrl_q[CTRL_ACQ_OFF];
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Accepted header control byte
  sequence hdr_ctrl_s;
    byte_valid_i && !off && pkt_num_i == PKT_HDR && byte_pos_i <= HDR_CTRL_LAST && hdr_match_i;
  endsequence
  // Unmatched time byte with good parity in serial mode
  sequence time_s;
    byte_valid_i && ctrl_q[5:0] == 6'h00 && pkt_num_i == PKT_HDR && !hdr_match_i
      && byte_pos_i >= COL_TIME_FIRST && ^byte_i;
  endsequence
  rdata_idle_a: assert property (!$past(reg_re_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside answer cycle");
  acq_off_a: assert property (off && $past(off) |-> !mem_we_o)
    else $error("write while acquisition off");
  time_write_a: assert property (time_s |=> mem_we_o && mem_row_o == 5'h00
    && mem_block_o == ctrl_q[11:8] && mem_col_o == $past(byte_pos_i)
    && mem_data_o == {1'b0, $past(byte_i[6:0])})
    else $error("time byte not written to display block");
  hdr_ctrl_a: assert property (hdr_ctrl_s |=> mem_we_o && mem_row_o == 5'h19
    && mem_col_o == $past(byte_pos_i) && mem_block_o == $past(match_block_i))
    else $error("control byte not in row 25");
  ham_flag_a: assert property (hdr_ctrl_s ##0 byte_i == 8'h16 |=> mem_data_o[4])
    else $error("error flag missing on bad control byte");
  green_code_a: assert property (mem_we_o && mem_row_o == 5'h00 && mem_col_o == 6'h07
    && !$past(byte_valid_i) |-> mem_data_o == 8'h02)
    else $error("wrong green code");
  flag_byte_a: assert property (mem_we_o && mem_row_o == 5'h19 && mem_col_o == 6'h09
    |-> mem_data_o == 8'h20)
    else $error("wrong changed flag byte");
  clear_space_a: assert property (clearing_o && mem_we_o && !$past(byte_valid_i)
    && mem_row_o inside {[5'h01:5'h17]} |-> mem_data_o == 8'h20)
    else $error("clear wrote non-space");
  roll_block_a: assert property (roll && $past(roll) && mem_we_o && mem_row_o == 5'h00
    |-> $past(byte_valid_i && hdr_match_i))
    else $error("row 0 written with roll disabled");
  parity_drop_a: assert property (byte_valid_i && !off && !ctrl_q[CTRL_EIGHT]
    && pkt_num_i == PKT_HDR && byte_pos_i > 6'h07 && !(^byte_i)
    |=> !(mem_we_o && mem_row_o == 5'h00 && mem_col_o == $past(byte_pos_i)))
    else $error("parity failure was stored");
endmodule
bind teletext_header_roll_and_error_check acq_checker chk_u (.*);

// ### test/byte_feed.sv
// Purpose: Recovery stage model handing over decoded bytes
// Assumes: One byte per call, matcher verdict given with the byte
// Notes:   Idle cycles show the inverted last byte and position
`timescale 1ns/1ps
module byte_feed #(parameter logic [3:0] BLK = 4'h3) (
  // Clock
  input wire logic clock_i,
  // Byte stream
  output logic byte_valid_o,
  output logic [4:0] pkt_num_o,
  output logic [2:0] pkt_mag_o,
  output logic [5:0] byte_pos_o,
  output logic [7:0] byte_o,
  output logic hdr_match_o,
  output logic [3:0] match_block_o
);
  assign match_block_o = BLK;
  initial begin
    {byte_valid_o, pkt_mag_o, hdr_match_o} = '0;
    pkt_num_o = 5'h1f;
    byte_pos_o = 6'h3f;
    byte_o = 8'hff;
  end
  // One byte, then idle cycles to drain pending writes
  task send(input logic [4:0] p, input logic [2:0] m, input logic [5:0] s,
            input logic [7:0] b, input logic h);
    @(posedge clock_i);
    byte_valid_o <= 1'b1;
    pkt_num_o <= p;
    pkt_mag_o <= m;
    byte_pos_o <= s;
    byte_o <= b;
    hdr_match_o <= h;
    @(posedge clock_i);
    byte_valid_o <= 1'b0;
    byte_o <= ~b;
    byte_pos_o <= ~s;
    @(posedge clock_i);
    @(negedge clock_i);
  endtask
endmodule

// ### test/testbench.sv
// Purpose: Self-checking bench of the write-control block
// Assumes: Request 3 and display block 3 throughout
// Notes:   Writes logged in a sparse array; checks at falling edges, register read data 1 ns after a rising edge
`timescale 1ns/1ps
module testbench
  import teletext_acq_pkg::*;
;
  logic clock_i, rst_i, reg_we_i, reg_re_i, tv_line_i, field_line1_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, d;
  logic byte_valid_i, hdr_match_i, mem_we_o, clearing_o, irq_o;
  logic [4:0] pkt_num_i, mem_row_o;
  logic [2:0] pkt_mag_i;
  logic [5:0] byte_pos_i, mem_col_o;
  logic [7:0] byte_i, mem_data_o;
  logic [3:0] reg_addr_i, match_block_i, mem_block_o;
  logic [7:0] mem [logic [14:0]];
  int wcnt, r0cnt, n, error_cnt, comparisons;
  teletext_header_roll_and_error_check dut_u (.*);
  byte_feed src_u (.clock_i(clock_i), .byte_valid_o(byte_valid_i), .pkt_num_o(pkt_num_i),
    .pkt_mag_o(pkt_mag_i), .byte_pos_o(byte_pos_i), .byte_o(byte_i),
    .hdr_match_o(hdr_match_i), .match_block_o(match_block_i));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Log writes; counters catch inhibited writes
  always @(posedge clock_i) begin
    if (mem_we_o === 1'b1) begin
      mem[{mem_block_o, mem_row_o, mem_col_o}] = mem_data_o;
      wcnt++;
      if (mem_row_o == 5'h00) r0cnt++;
    end
  end
  function automatic logic [7:0] mv(input logic [3:0] b, input logic [4:0] r,
                                    input logic [5:0] c);
    mv = mem.exists({b, r, c}) ? mem[{b, r, c}] : 8'hxx;
  endfunction
  task chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(negedge clock_i);
  endtask
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clock_i);
    reg_we_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clock_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_re_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // Line start pulse, optionally marking field line 1
  task pulse(input logic f);
    @(posedge clock_i);
    tv_line_i <= 1'b1;
    field_line1_i <= f;
    @(posedge clock_i);
    tv_line_i <= 1'b0;
    field_line1_i <= 1'b0;
  endtask
  // Clear wait, bounded well above one block
  task wclr;
    @(negedge clock_i);
    chk(clearing_o, 16'h0001);
    n = 0;
    while (clearing_o !== 1'b0 && n < 4000) begin
      @(negedge clock_i);
      n++;
    end
    chk(clearing_o, 16'h0000);
    cyc(2);
  endtask
  task give_verdict;
    $display("mismatches %0d of %0d comparisons", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    {reg_we_i, reg_re_i, tv_line_i, field_line1_i, reg_addr_i, reg_wdata_i} = '0;
    rst_i = 1'b1;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(REG_CTRL);
    chk(d, 16'h0000);
    wr(REG_REQ_SEL, 16'h00c0);
    wr(REG_REQ_DATA, 16'h0008);
    cyc(4);
    chk(mv(3, 25, 9), 16'h0020);
    rd(REG_FLAGS);
    chk(d, 16'h0000);
    pulse(1'b1);
    rd(REG_FLAGS);
    chk(d, 16'h0008);
    wr(REG_CTRL, 16'h0300);
    pulse(1'b0);
    cyc(4);
    chk(mv(3, 0, 7), 16'h0002);
    src_u.send(5'h00, 3'h1, 6'h0a, 8'hc1, 1'b0);
    src_u.send(5'h00, 3'h1, 6'h23, 8'h32, 1'b0);
    chk(mv(3, 0, 10), 16'h0041);
    chk(mv(3, 0, 35), 16'h0032);
    wr(REG_CTRL, 16'h0320);
    src_u.send(5'h00, 3'h1, 6'h0b, 8'hc1, 1'b0);
    src_u.send(5'h00, 3'h0, 6'h0c, 8'hc1, 1'b0);
    src_u.send(5'h00, 3'h0, 6'h0d, 8'h41, 1'b0);
    chk(mv(3, 0, 11), 16'h00xx);
    chk(mv(3, 0, 12), 16'h0041);
    chk(mv(3, 0, 13), 16'h00xx);
    chk(irq_o, 16'h0000);
    wr(REG_MASK, 16'h0004);
    cyc(2);
    chk(irq_o, 16'h0001);
    wr(REG_STATUS, 16'h0004);
    cyc(2);
    chk(irq_o, 16'h0000);
    pulse(1'b1);
    src_u.send(5'h00, 3'h0, 6'h00, 8'h15, 1'b1);
    wclr();
    chk(mv(3, 1, 0), 16'h0020);
    chk(mv(3, 23, 39), 16'h0020);
    chk(mv(3, 24, 0), 16'h00xx);
    chk(mv(9, 8, 0), 16'h00xx);
    chk(mv(3, 25, 0), 16'h0000);
    src_u.send(5'h00, 3'h0, 6'h01, 8'h16, 1'b1);
    chk(mv(3, 25, 1) & 16'h0010, 16'h0010);
    wr(REG_REQ_SEL, 16'h00f8);
    wr(REG_REQ_DATA, 16'h0002);
    src_u.send(5'h01, 3'h0, 6'h05, 8'h15, 1'b1);
    src_u.send(5'h01, 3'h0, 6'h06, 8'h16, 1'b1);
    src_u.send(5'h1b, 3'h0, 6'h02, 8'h16, 1'b1);
    chk(mv(3, 1, 5), 16'h0000);
    chk(mv(3, 1, 6), 16'h0020);
    chk(mv(9, 9, 2), 16'h00xx);
    wr(REG_CTRL, 16'h0326);
    pulse(1'b1);
    src_u.send(5'h00, 3'h0, 6'h00, 8'h15, 1'b1);
    wclr();
    chk(mv(3, 24, 0), 16'h0020);
    chk(mv(9, 8, 0), 16'h0020);
    chk(mv(9, 9, 39), 16'h0020);
    wr(REG_CTRL, 16'h0327);
    n = r0cnt;
    src_u.send(5'h00, 3'h0, 6'h21, 8'h32, 1'b0);
    pulse(1'b0);
    cyc(4);
    chk(16'(r0cnt - n), 16'h0000);
    src_u.send(5'h00, 3'h0, 6'h15, 8'hc1, 1'b1);
    chk(mv(3, 0, 21), 16'h0041);
    wr(REG_CTRL, 16'h0308);
    n = wcnt;
    wr(REG_REQ_DATA, 16'h0008);
    src_u.send(5'h00, 3'h0, 6'h22, 8'h32, 1'b0);
    src_u.send(5'h01, 3'h0, 6'h03, 8'h15, 1'b1);
    pulse(1'b0);
    cyc(8);
    chk(16'(wcnt - n), 16'h0000);
    give_verdict();
  end
endmodule
